// ---- verilog/tws_defines.svh ----
`ifndef TWS_DEFINES_SVH
`define TWS_DEFINES_SVH

// ----------------------------------------------------------------
// Addressing
// ----------------------------------------------------------------
`define TWS_ADDR_HI6      6'h26
`define TWS_TOP_REG       8'h2E
`define TWS_PTR_RST       8'h00

// ----------------------------------------------------------------
// Byte framing
// ----------------------------------------------------------------
`define TWS_BYTE_BITS     4'h8
`define TWS_LAST_TX_BIT   4'h7
`define TWS_MSB_IDX       3'h7

// ----------------------------------------------------------------
// Synchronisers and buffer
// ----------------------------------------------------------------
`define TWS_SLV_SYNC_INIT 3'h3
`define TWS_MST_SYNC_INIT 2'h3
`define TWS_FIFO_DEPTH    2'h2

// ----------------------------------------------------------------
// Link clock made by the master
// ----------------------------------------------------------------
`define TWS_CLK_PERIOD_NS 200
`define TWS_SYS_PERIOD_NS 4
`define TWS_PHASES        4
`define TWS_QTR_CYC       (`TWS_CLK_PERIOD_NS / (`TWS_PHASES * `TWS_SYS_PERIOD_NS))
`define TWS_LAST_PHASE    2'h3

`endif

// ---- verilog/tws_pkg.sv ----
`default_nettype none
package tws_pkg;
    typedef enum logic [6:0] {
        TWS_S_IDLE     = 7'h01,
        TWS_S_ADDR     = 7'h02,
        TWS_S_ACK_ADDR = 7'h04,
        TWS_S_RX       = 7'h08,
        TWS_S_ACK_RX   = 7'h10,
        TWS_S_TX       = 7'h20,
        TWS_S_ACK_TX   = 7'h40
    } tws_slv_state_t;

    typedef enum logic [3:0] {
        TWS_M_IDLE  = 4'h1,
        TWS_M_START = 4'h2,
        TWS_M_BIT   = 4'h4,
        TWS_M_STOP  = 4'h8
    } tws_mst_state_t;
endpackage
`default_nettype wire

// ---- verilog/tws_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface tws_if;
    logic m_scl_o;
    logic m_scl_oe;
    logic m_sda_o;
    logic m_sda_oe;
    logic s_scl_o;
    logic s_scl_oe;
    logic s_sda_o;
    logic s_sda_oe;
    wire  scl;
    wire  sda;

    // Open-drain lines with pull-ups
    assign scl = ((m_scl_oe & ~m_scl_o) | (s_scl_oe & ~s_scl_o)) ? 1'h0 : 1'h1;
    assign sda = ((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o)) ? 1'h0 : 1'h1;

    modport master (
        output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe,
        input  scl, sda
    );
    modport slave (
        output s_scl_o, s_scl_oe, s_sda_o, s_sda_oe,
        input  scl, sda
    );
endinterface // tws_if
`default_nettype wire

// ---- verilog/tws_slave.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tws_defines.svh"
module tws_slave import tws_pkg::*; (
    // Clock and reset
    input  wire logic       i_clock,
    input  wire logic       i_rstn,
    // Two-wire link
    tws_if.slave            bus,
    // Address strap
    input  wire logic       i_addr_lsb_select_pin,
    // Register read port
    input  wire logic [7:0] i_reg_rdata,
    output logic      [7:0] o_reg_addr,
    // Register write stream
    output logic            o_wr_valid,
    input  wire logic       i_wr_ready,
    output logic      [7:0] o_wr_addr,
    output logic      [7:0] o_wr_data,
    // Status
    output logic            o_busy
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] sat_inc(input logic [7:0] p);
        sat_inc = (p >= `TWS_TOP_REG) ? `TWS_TOP_REG : p + 8'h01;
    endfunction

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic [2:0] raw;
    logic [2:0] sy1;
    logic [2:0] sy2;
    logic [2:0] sy3;
    logic [2:0] filt;
    logic [2:0] filt_d;
    logic [2:0] next_filt;

    assign raw       = {i_addr_lsb_select_pin, bus.sda, bus.scl};
    assign next_filt = ((sy2 ~^ sy3) & sy3) | ((sy2 ^ sy3) & filt);

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            sy1    <= `TWS_SLV_SYNC_INIT;
            sy2    <= `TWS_SLV_SYNC_INIT;
            sy3    <= `TWS_SLV_SYNC_INIT;
            filt   <= `TWS_SLV_SYNC_INIT;
            filt_d <= `TWS_SLV_SYNC_INIT;
        end else begin
            sy1    <= raw;
            sy2    <= sy1;
            sy3    <= sy2;
            filt   <= next_filt;
            filt_d <= filt;
        end
    end

    // ----------------------------------------------------------------
    // Line events
    // ----------------------------------------------------------------
    logic scl_rise;
    logic scl_fall;
    logic sda_s;
    logic start_ev;
    logic stop_ev;

    assign sda_s    = filt[1];
    assign scl_rise = filt[0] & ~filt_d[0];
    assign scl_fall = ~filt[0] & filt_d[0];
    assign start_ev = filt[0] & filt_d[0] & filt_d[1] & ~filt[1];
    assign stop_ev  = filt[0] & filt_d[0] & ~filt_d[1] & filt[1];

    // ----------------------------------------------------------------
    // Write buffer
    // ----------------------------------------------------------------
    logic [7:0] mem_addr [2];
    logic [7:0] mem_data [2];
    logic       wp;
    logic       rp;
    logic [1:0] fcnt;
    logic       fifo_rdy;
    logic       pend;
    logic       push;
    logic       pop;
    logic [7:0] shift;

    assign fifo_rdy   = fcnt != `TWS_FIFO_DEPTH;
    assign push       = pend & fifo_rdy;
    assign o_wr_valid = fcnt != 2'h0;
    assign pop        = o_wr_valid & i_wr_ready;
    assign o_wr_addr  = mem_addr[rp];
    assign o_wr_data  = mem_data[rp];

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            wp   <= 1'h0;
            rp   <= 1'h0;
            fcnt <= 2'h0;
        end else begin
            wp   <= wp ^ push;
            rp   <= rp ^ pop;
            fcnt <= fcnt + {1'h0, push} - {1'h0, pop};
        end
    end

    always_ff @(posedge i_clock) begin
        if (push) begin
            mem_addr[wp] <= o_reg_addr;
            mem_data[wp] <= shift;
        end
    end

    // ----------------------------------------------------------------
    // Protocol engine
    // ----------------------------------------------------------------
    tws_slv_state_t state;
    logic [3:0]     cnt;
    logic           rw;
    logic           first;
    logic           mack;
    logic           sda_oe;
    logic [7:0]     ptr;
    logic           addr_hit;
    logic           base_ok;

    assign addr_hit   = shift[7:1] == {`TWS_ADDR_HI6, filt[2]};
    assign base_ok    = shift <= `TWS_TOP_REG;
    assign o_reg_addr = ptr;
    assign o_busy     = state != TWS_S_IDLE;

    // Open-drain drivers
    assign bus.s_sda_o  = 1'h0;
    assign bus.s_sda_oe = sda_oe;
    assign bus.s_scl_o  = 1'h0;
    assign bus.s_scl_oe = pend & ~fifo_rdy;

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            state  <= TWS_S_IDLE;
            cnt    <= 4'h0;
            shift  <= 8'h00;
            rw     <= 1'h0;
            first  <= 1'h0;
            mack   <= 1'h0;
            sda_oe <= 1'h0;
            ptr    <= `TWS_PTR_RST;
            pend   <= 1'h0;
        end else begin
            if (push) begin
                pend <= 1'h0;
                ptr  <= sat_inc(ptr);
            end
            if (start_ev) begin
                // Pointer untouched on repeated start
                state  <= TWS_S_ADDR;
                cnt    <= 4'h0;
                sda_oe <= 1'h0;
            end else if (stop_ev) begin
                state  <= TWS_S_IDLE;
                sda_oe <= 1'h0;
            end else begin
                case (state)
                    TWS_S_ADDR, TWS_S_RX: begin
                        if (scl_rise && cnt != `TWS_BYTE_BITS) begin
                            shift <= {shift[6:0], sda_s};
                            cnt   <= cnt + 4'h1;
                        end
                        if (scl_fall && cnt == `TWS_BYTE_BITS) begin
                            cnt <= 4'h0;
                            if (state == TWS_S_ADDR) begin
                                rw     <= shift[0];
                                sda_oe <= addr_hit;
                                state  <= addr_hit ? TWS_S_ACK_ADDR
                                                   : TWS_S_IDLE;
                            end else if (first) begin
                                first  <= 1'h0;
                                sda_oe <= base_ok;
                                state  <= base_ok ? TWS_S_ACK_RX
                                                  : TWS_S_IDLE;
                                if (base_ok) begin
                                    ptr <= shift;
                                end
                            end else begin
                                sda_oe <= 1'h1;
                                pend   <= 1'h1;
                                state  <= TWS_S_ACK_RX;
                            end
                        end
                    end
                    TWS_S_ACK_ADDR: begin
                        if (scl_fall) begin
                            cnt <= 4'h0;
                            if (rw) begin
                                shift  <= i_reg_rdata;
                                sda_oe <= ~i_reg_rdata[`TWS_MSB_IDX];
                                state  <= TWS_S_TX;
                            end else begin
                                sda_oe <= 1'h0;
                                first  <= 1'h1;
                                state  <= TWS_S_RX;
                            end
                        end
                    end
                    TWS_S_ACK_RX: begin
                        if (scl_fall) begin
                            sda_oe <= 1'h0;
                            state  <= TWS_S_RX;
                        end
                    end
                    TWS_S_TX: begin
                        if (scl_fall) begin
                            if (cnt == `TWS_LAST_TX_BIT) begin
                                sda_oe <= 1'h0;
                                ptr    <= sat_inc(ptr);
                                state  <= TWS_S_ACK_TX;
                            end else begin
                                shift  <= {shift[6:0], 1'h0};
                                sda_oe <= ~shift[6];
                                cnt    <= cnt + 4'h1;
                            end
                        end
                    end
                    TWS_S_ACK_TX: begin
                        if (scl_rise) begin
                            mack <= ~sda_s;
                        end
                        if (scl_fall) begin
                            cnt <= 4'h0;
                            if (mack) begin
                                shift  <= i_reg_rdata;
                                sda_oe <= ~i_reg_rdata[`TWS_MSB_IDX];
                                state  <= TWS_S_TX;
                            end else begin
                                sda_oe <= 1'h0;
                                state  <= TWS_S_IDLE;
                            end
                        end
                    end
                    TWS_S_IDLE: begin
                        sda_oe <= 1'h0;
                    end
                    default: begin
                        state  <= TWS_S_IDLE;
                        sda_oe <= 1'h0;
                    end
                endcase
            end
        end
    end

endmodule // tws_slave
`default_nettype wire

// ---- verilog/tws_master.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tws_defines.svh"
module tws_master import tws_pkg::*; (
    // Clock and reset
    input  wire logic       i_clock,
    input  wire logic       i_rstn,
    // Two-wire link
    tws_if.master           bus,
    // Byte command
    input  wire logic       i_cmd_valid,
    output logic            o_cmd_ready,
    input  wire logic       i_cmd_start,
    input  wire logic       i_cmd_stop,
    input  wire logic       i_cmd_read,
    input  wire logic       i_cmd_nack,
    input  wire logic [7:0] i_cmd_wdata,
    // Byte result
    output logic            o_rsp_valid,
    output logic      [7:0] o_rsp_data,
    output logic            o_rsp_ack,
    // Status
    output logic            o_busy
);

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic [1:0] sy1;
    logic [1:0] sy2;
    logic [1:0] sy3;
    logic [1:0] filt;
    logic [1:0] next_filt;
    logic       scl_s;
    logic       sda_s;

    assign next_filt = ((sy2 ~^ sy3) & sy3) | ((sy2 ^ sy3) & filt);
    assign scl_s     = filt[0];
    assign sda_s     = filt[1];

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            sy1  <= `TWS_MST_SYNC_INIT;
            sy2  <= `TWS_MST_SYNC_INIT;
            sy3  <= `TWS_MST_SYNC_INIT;
            filt <= `TWS_MST_SYNC_INIT;
        end else begin
            sy1  <= {bus.sda, bus.scl};
            sy2  <= sy1;
            sy3  <= sy2;
            filt <= next_filt;
        end
    end

    // ----------------------------------------------------------------
    // Quarter-period divider
    // ----------------------------------------------------------------
    tws_mst_state_t state;
    logic [1:0]     phase;
    logic [3:0]     qcnt;
    logic           tick;
    logic           hold;

    // Wait while the slave stretches the clock low
    assign hold   = state == TWS_M_BIT && phase == 2'h2 && !scl_s;
    assign tick   = !hold && qcnt == 4'(`TWS_QTR_CYC - 1);

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            qcnt <= 4'h0;
        end else if (state == TWS_M_IDLE || hold || tick) begin
            qcnt <= 4'h0;
        end else begin
            qcnt <= qcnt + 4'h1;
        end
    end

    // ----------------------------------------------------------------
    // Bit sequencer
    // ----------------------------------------------------------------
    logic [3:0] bidx;
    logic [7:0] tx;
    logic       rd;
    logic       nack;
    logic       stop_after;
    logic       scl_low;
    logic       sda_low;
    logic       drv_low;
    logic       ack_bit;

    assign ack_bit     = bidx == `TWS_BYTE_BITS;
    assign drv_low     = ack_bit ? (rd & ~nack) : (~rd & ~tx[7]);
    assign o_cmd_ready = state == TWS_M_IDLE;
    assign o_busy      = !o_cmd_ready;

    // Open-drain drivers
    assign bus.m_scl_o  = 1'h0;
    assign bus.m_scl_oe = scl_low;
    assign bus.m_sda_o  = 1'h0;
    assign bus.m_sda_oe = sda_low;

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            state       <= TWS_M_IDLE;
            phase       <= 2'h0;
            bidx        <= 4'h0;
            tx          <= 8'h00;
            rd          <= 1'h0;
            nack        <= 1'h0;
            stop_after  <= 1'h0;
            scl_low     <= 1'h0;
            sda_low     <= 1'h0;
            o_rsp_valid <= 1'h0;
            o_rsp_data  <= 8'h00;
            o_rsp_ack   <= 1'h0;
        end else begin
            o_rsp_valid <= 1'h0;
            if (tick) begin
                phase <= phase + 2'h1;
            end
            case (state)
                TWS_M_IDLE: begin
                    phase <= 2'h0;
                    bidx  <= 4'h0;
                    if (i_cmd_valid) begin
                        tx         <= i_cmd_wdata;
                        rd         <= i_cmd_read;
                        nack       <= i_cmd_nack;
                        stop_after <= i_cmd_stop;
                        state      <= i_cmd_start ? TWS_M_START
                                                  : TWS_M_BIT;
                    end
                end
                TWS_M_START: begin
                    if (tick) begin
                        case (phase)
                            2'h0: sda_low <= 1'h0;
                            2'h1: scl_low <= 1'h0;
                            2'h2: sda_low <= 1'h1;
                            default: begin
                                scl_low <= 1'h1;
                                state   <= TWS_M_BIT;
                            end
                        endcase
                    end
                end
                TWS_M_BIT: begin
                    if (tick) begin
                        case (phase)
                            2'h0: sda_low <= drv_low;
                            2'h1: scl_low <= 1'h0;
                            2'h2: begin
                                if (ack_bit) begin
                                    o_rsp_ack <= ~sda_s;
                                end else begin
                                    o_rsp_data <= {o_rsp_data[6:0], sda_s};
                                end
                            end
                            default: begin
                                scl_low <= 1'h1;
                                tx      <= {tx[6:0], 1'h0};
                                bidx    <= bidx + 4'h1;
                                if (ack_bit) begin
                                    o_rsp_valid <= 1'h1;
                                    state <= stop_after ? TWS_M_STOP
                                                        : TWS_M_IDLE;
                                end
                            end
                        endcase
                    end
                end
                TWS_M_STOP: begin
                    if (tick) begin
                        case (phase)
                            2'h0: sda_low <= 1'h1;
                            2'h1: scl_low <= 1'h0;
                            2'h2: sda_low <= 1'h0;
                            default: state <= TWS_M_IDLE;
                        endcase
                    end
                end
                default: state <= TWS_M_IDLE;
            endcase
        end
    end

endmodule // tws_master
`default_nettype wire

// ---- tb/tws_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module tws_monitor (
    // Clock and reset
    input  wire logic i_clock,
    input  wire logic i_rstn,
    // Line drivers and resolved lines
    input  wire logic m_scl_o,
    input  wire logic m_scl_oe,
    input  wire logic m_sda_o,
    input  wire logic m_sda_oe,
    input  wire logic s_scl_o,
    input  wire logic s_scl_oe,
    input  wire logic s_sda_o,
    input  wire logic s_sda_oe,
    input  wire logic scl,
    input  wire logic sda
);
    // ----------------------------------------------------------------
    // Line checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rstn);

    chk_slv_sda_low: assert property (!s_sda_o)
        else $error("slave data value not low");
    chk_slv_scl_low: assert property (!s_scl_o)
        else $error("slave clock value not low");
    chk_mst_pull_low: assert property (!m_sda_o && !m_scl_o)
        else $error("master line value not low");
    chk_sda_hold_high: assert property (
        scl && $past(scl) |-> $stable(s_sda_oe))
        else $error("slave data changed while clock high");
    chk_drive_after_sync: assert property (
        $rose(s_sda_oe) |-> !$past(scl, 3))
        else $error("slave drove data before clock fall synced");
    chk_stretch_low: assert property (
        $rose(s_scl_oe) |-> !scl && !$past(scl, 3))
        else $error("slave stretch began outside clock low");
    chk_start_release: assert property (
        $fell(sda) && scl |-> !s_sda_oe [*8])
        else $error("slave drove data after start");
    chk_stop_release: assert property (
        $rose(sda) && scl |-> (!s_sda_oe && !s_scl_oe) [*8])
        else $error("slave drove a line after stop");

    cov_start: cover property ($fell(sda) && scl);
    cov_stop: cover property ($rose(sda) && scl);
    cov_ack: cover property ($rose(s_sda_oe));
    cov_stretch: cover property ($rose(s_scl_oe));
endmodule // tws_monitor
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tws_defines.svh"
module tb;
    // ----------------------------------------------------------------
    // Stimulus, ends and checks
    // ----------------------------------------------------------------
    logic       i_clock = 1'h0;
    logic       i_rstn  = 1'h0;
    logic       pin     = 1'h0;
    logic       rdy     = 1'h1;
    logic       cv      = 1'h0;
    logic       cs      = 1'h0;
    logic       cp      = 1'h0;
    logic       cr      = 1'h0;
    logic       cn      = 1'h0;
    logic [7:0] cw      = 8'h00;
    logic [7:0] rd_data;
    logic       rd_ack;
    int         err_total = 0;
    int         cmp_count = 0;
    logic [7:0] wa[$];
    logic [7:0] wd[$];
    wire        c_rdy, r_vld, r_ack, m_busy, s_busy, w_vld;
    wire  [7:0] r_dat, reg_addr, w_addr, w_data;
    wire  [7:0] reg_rdata = ~reg_addr;

    always #2 i_clock = ~i_clock;

    tws_if bus_if ();
    tws_slave i_tws_slave (.i_clock(i_clock), .i_rstn(i_rstn), .bus(bus_if),
        .i_addr_lsb_select_pin(pin), .i_reg_rdata(reg_rdata),
        .o_reg_addr(reg_addr), .o_wr_valid(w_vld), .i_wr_ready(rdy),
        .o_wr_addr(w_addr), .o_wr_data(w_data), .o_busy(s_busy));
    tws_master i_tws_master (.i_clock(i_clock), .i_rstn(i_rstn),
        .bus(bus_if), .i_cmd_valid(cv), .o_cmd_ready(c_rdy),
        .i_cmd_start(cs), .i_cmd_stop(cp), .i_cmd_read(cr),
        .i_cmd_nack(cn), .i_cmd_wdata(cw), .o_rsp_valid(r_vld),
        .o_rsp_data(r_dat), .o_rsp_ack(r_ack), .o_busy(m_busy));
    tws_monitor i_tws_monitor (.i_clock(i_clock), .i_rstn(i_rstn),
        .m_scl_o(bus_if.m_scl_o), .m_scl_oe(bus_if.m_scl_oe),
        .m_sda_o(bus_if.m_sda_o), .m_sda_oe(bus_if.m_sda_oe),
        .s_scl_o(bus_if.s_scl_o), .s_scl_oe(bus_if.s_scl_oe),
        .s_sda_o(bus_if.s_sda_o), .s_sda_oe(bus_if.s_sda_oe),
        .scl(bus_if.scl), .sda(bus_if.sda));

    always @(negedge i_clock) begin
        if (w_vld === 1'h1 && rdy === 1'h1) begin
            wa.push_back(w_addr);
            wd.push_back(w_data);
        end
    end

    task automatic tally_and_finish();
        $display("Compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
            err_total++;
        end
    endtask

    task automatic ack_is(input logic exp);
        chk({7'h00, rd_ack}, {7'h00, exp});
    endtask

    function automatic logic [7:0] sat(input int v);
        return (v > `TWS_TOP_REG) ? `TWS_TOP_REG : v[7:0];
    endfunction

    // One byte command, returns after the response and any stop
    task automatic xfer(input logic st, sp, rd, nk, input logic [7:0] b);
        int   n;
        logic seen;
        n    = 0;
        seen = 1'h0;
        chk({7'h00, c_rdy}, 8'h01);
        {cs, cp, cr, cn, cw} = {st, sp, rd, nk, b};
        cv = 1'h1;
        @(posedge i_clock) #1;
        cv = 1'h0;
        while (seen !== 1'h1 || m_busy !== 1'h0) begin
            if (r_vld === 1'h1) begin
                seen    = 1'h1;
                rd_data = r_dat;
                rd_ack  = r_ack;
            end
            if (n++ > 4000) begin
                $display("ERROR t=%0t wait bound used up", $time);
                err_total++;
                tally_and_finish();
            end
            @(posedge i_clock) #1;
        end
    endtask

    task automatic addr_base(input logic [7:0] base);
        xfer(1'h1, 1'h0, 1'h0, 1'h0, {`TWS_ADDR_HI6, pin, 1'h0});
        ack_is(1'h1);
        xfer(1'h0, 1'h0, 1'h0, 1'h0, base);
        ack_is(1'h1);
    endtask

    task automatic refuse();
        xfer(1'h1, 1'h1, 1'h0, 1'h0, {`TWS_ADDR_HI6, ~pin, 1'h0});
        ack_is(1'h0);
        xfer(1'h1, 1'h0, 1'h0, 1'h0, {`TWS_ADDR_HI6, pin, 1'h0});
        ack_is(1'h1);
        xfer(1'h0, 1'h1, 1'h0, 1'h0, `TWS_TOP_REG + 8'h01);
        ack_is(1'h0);
        chk(8'(wa.size()), 8'h00);
        $display("Refusal test done");
    endtask

    task automatic wr_seq(input logic [7:0] base, input int cnt);
        addr_base(base);
        for (int i = 0; i < cnt; i++) begin
            xfer(1'h0, i == cnt - 1, 1'h0, 1'h0, 8'hA5 ^ i[7:0]);
            ack_is(1'h1);
        end
        for (int i = 0; i < cnt; i++) begin
            chk(wa.pop_front(), sat(base + i));
            chk(wd.pop_front(), 8'hA5 ^ i[7:0]);
        end
        chk({7'h00, s_busy}, 8'h00);
        $display("Write of %0d at %h done", cnt, base);
    endtask

    task automatic rd_seq(input logic [7:0] base, input int cnt);
        addr_base(base);
        xfer(1'h1, 1'h0, 1'h0, 1'h0, {`TWS_ADDR_HI6, pin, 1'h1});
        ack_is(1'h1);
        for (int i = 0; i < cnt; i++) begin
            xfer(1'h0, i == cnt - 1, 1'h1, i == cnt - 1, 8'hFF);
            chk(rd_data, ~sat(base + i));
        end
        chk({7'h00, s_busy}, 8'h00);
        $display("Read of %0d at %h done", cnt, base);
    endtask

    task automatic stall();
        rdy = 1'h0;
        fork
            wr_seq(8'h20, 4);
            begin
                repeat (2500) @(posedge i_clock);
                #1 rdy = 1'h1;
            end
        join
    endtask

    initial begin
        repeat (10) @(posedge i_clock);
        #1 i_rstn = 1'h1;
        for (int p = 0; p < 2; p++) begin
            pin = p[0];
            repeat (8) @(posedge i_clock);
            #1;
            refuse();
            wr_seq(8'h10, 4);
            rd_seq(8'h10, 4);
        end
        wr_seq(8'h2D, 3);
        rd_seq(8'h2C, 4);
        stall();
        tally_and_finish();
    end
endmodule // tb
`default_nettype wire
